// ---- sia_cfg.svh ----
// Purpose: constants of the integrity alarm monitor
// Assumes: 40 MHz clock, 32-bit APB
// Notes: offsets are byte addresses
`ifndef SIA_CFG_SVH
`define SIA_CFG_SVH
`define SIA_OFF_CTRL 12'h000
`define SIA_OFF_MINSAT 12'h004
`define SIA_OFF_PRCLIM 12'h008
`define SIA_OFF_RRCLIM 12'h00c
`define SIA_OFF_FBLIM 12'h010
`define SIA_OFF_DNUPER 12'h014
`define SIA_OFF_STNID 12'h018
`define SIA_OFF_HCMD 12'h01c
`define SIA_OFF_ALARM 12'h020
`define SIA_OFF_SATSEL 12'h024
`define SIA_OFF_SATSTAT 12'h028
`define SIA_OFF_FBSTAT 12'h02c
`define SIA_CTRL_ONCHG_BIT 0
`define SIA_CTRL_QUERY_BIT 1
`define SIA_CTRL_HLTH_LSB 4
`define SIA_HCMD_CODE_LSB 8
`define SIA_RST_MINSAT 6'h03
`define SIA_RST_PRCLIM 16'hfffe
`define SIA_RST_RRCLIM 16'h03e8
`define SIA_RST_FBLIM 8'h1e
`define SIA_RST_DNUPER 8'h1e
`define SIA_RST_STNID 10'h000
`define SIA_CLK_NS 25
`define SIA_TICK_NS 100000000
`define SIA_TICKS_PER_SEC 4'h9
`define SIA_ALL_SATS 7'h63
`define SIA_UNHEALTHY 3'h7
`define SIA_CH_I 8'h49
`define SIA_CH_S 8'h53
`define SIA_CH_F 8'h46
`define SIA_CH_W 8'h57
`define SIA_CH_U 8'h55
`define SIA_CH_M 8'h4d
`define SIA_CH_H 8'h48
`define SIA_CH_N 8'h4e
`endif

// ---- sia_fb_model.sv ----
// Purpose: stand-in for the integrity monitor that feeds the block with feedback messages
// Assumes: fields are meaningful only while the one-cycle strobe is high
// Notes: a residual is carried by one message only, so a flagged satellite is not flagged again while res keeps its value
`timescale 1ns/10ps
module sia_fb_model (
	input wire logic clk,
	input wire logic on,
	input wire logic [9:0] id,
	input wire logic [1:0] pos,
	input wire logic dilutionHigh,
	input wire logic [5:0] res,
	output logic fbValid,
	output logic [9:0] fbStationId,
	output logic [1:0] fbPosFlag,
	output logic [5:0] fbResidual
);
	int cnt = 0;
	logic [5:0] lastRes = 6'h00;
	initial begin
		fbValid = 1'b0;
		fbStationId = 10'h000;
		fbPosFlag = 2'h0;
		fbResidual = 6'h00;
	end
	// one message every 20 cycles; between messages the fields flip so stale data never looks valid
	always @(posedge clk) begin
		cnt <= (cnt == 19) ? 0 : cnt + 1;
		fbValid <= on && cnt == 0;
		if (on && cnt == 0) begin
			fbStationId <= id;
			fbPosFlag <= dilutionHigh ? 2'h2 : pos;
			fbResidual <= (res != lastRes) ? res : 6'h00;
			lastRes <= res;
		end else begin
			fbStationId <= ~fbStationId;
			fbPosFlag <= ~fbPosFlag;
			fbResidual <= ~fbResidual;
		end
	end
endmodule

// ---- sia_mem_if.sv ----
// Purpose: link between the monitor and its override store
// Assumes: one write and one read port
// Notes: read data is registered inside the store
`timescale 1ns/10ps
interface sia_mem_if #(parameter int W = 2, parameter int A = 5);
	logic we;
	logic [A-1:0] waddr;
	logic [W-1:0] wdata;
	logic [A-1:0] raddr;
	logic [W-1:0] rdata;
	modport owner(output we, output waddr, output wdata, output raddr, input rdata);
	modport store(input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ---- sia_monitor.sv ----
// Purpose: satellite health override, alarm monitor and feedback handling
// Assumes: feedback and receiver inputs are on clk; APB slave
// Notes: one wait state on every APB access outside an override sweep; an access during a sweep waits until it ends
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`include "sia_cfg.svh"
module sia_monitor #(
	parameter int TICK_CYCLES = `SIA_TICK_NS / `SIA_CLK_NS,
	parameter int NSAT = 32
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [5:0] satCount,
	input wire logic [15:0] pseudorangeMag,
	input wire logic [15:0] rangeRateMag,
	input wire logic [NSAT-1:0] satTracked,
	input wire logic [NSAT-1:0] bcastHealthy,
	input wire logic fbValid,
	input wire logic [9:0] fbStationId,
	input wire logic [1:0] fbPosFlag,
	input wire logic [5:0] fbResidual,
	output logic reportValid,
	output logic [31:0] reportCodes,
	output logic [2:0] stationHealth,
	output logic unmonHeader,
	output logic [NSAT-1:0] dnuMask,
	output logic [NSAT-1:0] smoothReset
);
	import sia_pkg::*;

	// combined status code of one satellite
	function automatic logic [3:0] statusCode(input logic [1:0] ovr, input logic trk, input logic hlth);
		logic [3:0] c;
		c = 4'h0;
		unique case (ovr)
			SIA_OVR_HEALTHY: c = !trk ? 4'h5 : (hlth ? 4'h4 : 4'h3);
			SIA_OVR_UNHEALTHY: c = !trk ? 4'h8 : (hlth ? 4'h6 : 4'h7);
			default: c = !trk ? 4'h0 : (hlth ? 4'h1 : 4'h2);
		endcase
		return c;
	endfunction

	// alarm letter from a raised flag
	function automatic logic [7:0] almChar(input logic raised, input logic [7:0] up, input logic [7:0] clr);
		return raised ? up : clr;
	endfunction

	sia_mem_if #(.W(2), .A(5)) mem();
	sia_ovr_mem #(.W(2), .D(NSAT), .A(5)) u_mem(.clk(clk), .mem(mem));

	sia_bus_t busSt_r, busSt_nxt;
	logic [31:0] prdata_nxt;
	logic pready_nxt, pslverr_nxt;
	logic onChg_r, onChg_nxt, query_r, query_nxt;
	logic [2:0] baseHlth_r, baseHlth_nxt;
	logic [5:0] minSat_r, minSat_nxt;
	logic [15:0] pseudorangeLim_r, pseudorangeLim_nxt, rangeRateLim_r, rangeRateLim_nxt;
	logic [7:0] fbLim_r, fbLim_nxt, dnuPer_r, dnuPer_nxt;
	logic [9:0] stnId_r, stnId_nxt;
	logic [4:0] satSel_r, satSel_nxt;
	logic sweepAct_r, sweepAct_nxt;
	logic [4:0] sweepIdx_r, sweepIdx_nxt;
	logic [1:0] sweepCode_r, sweepCode_nxt;
	logic wrEn, hcmdWr;
	logic [6:0] hcmdSat;
	logic [31:0] codesNow;
	logic [7:0] fbAge_r, fbAge_nxt;
	logic [1:0] posFlag_r, posFlag_nxt;
	logic wrongId_r, wrongId_nxt;

	// register writes happen only at the edge that ends the acked access
	assign wrEn = busSt_r == SIA_BUS_ACK && psel && penable && pwrite;
	assign hcmdWr = wrEn && paddr == `SIA_OFF_HCMD;
	assign hcmdSat = pwdata[6:0];

	// override store port: the sweep owns it while active
	always_comb begin
		mem.raddr = satSel_r;
		mem.we = 1'b0;
		mem.waddr = sweepIdx_r;
		mem.wdata = sweepCode_r;
		if (sweepAct_r) begin
			mem.we = 1'b1;
		end else if (hcmdWr && hcmdSat >= 7'h01 && hcmdSat <= 7'h20) begin
			mem.we = 1'b1;
			mem.waddr = 5'(hcmdSat - 7'h01);
			mem.wdata = pwdata[`SIA_HCMD_CODE_LSB +: 2];
		end
	end

	// bus slave and software registers
	always_comb begin
		busSt_nxt = SIA_BUS_IDLE;
		prdata_nxt = prdata;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		onChg_nxt = onChg_r;
		query_nxt = 1'b0;
		baseHlth_nxt = baseHlth_r;
		minSat_nxt = minSat_r;
		pseudorangeLim_nxt = pseudorangeLim_r;
		rangeRateLim_nxt = rangeRateLim_r;
		fbLim_nxt = fbLim_r;
		dnuPer_nxt = dnuPer_r;
		stnId_nxt = stnId_r;
		satSel_nxt = satSel_r;
		sweepAct_nxt = sweepAct_r && sweepIdx_r != 5'h1f;
		sweepIdx_nxt = sweepAct_r ? sweepIdx_r + 5'h01 : 5'h00;
		sweepCode_nxt = sweepCode_r;
		unique case (busSt_r)
			SIA_BUS_IDLE: begin
				// a running sweep stalls the bus so no command overlaps it
				if (psel && penable && !sweepAct_r) begin
					busSt_nxt = SIA_BUS_ACK;
					pready_nxt = 1'b1;
					prdata_nxt = 32'h0;
					unique case (paddr)
						`SIA_OFF_CTRL: prdata_nxt = {25'h0, baseHlth_r, 3'h0, onChg_r};
						`SIA_OFF_MINSAT: prdata_nxt = {26'h0, minSat_r};
						`SIA_OFF_PRCLIM: prdata_nxt = {16'h0, pseudorangeLim_r};
						`SIA_OFF_RRCLIM: prdata_nxt = {16'h0, rangeRateLim_r};
						`SIA_OFF_FBLIM: prdata_nxt = {24'h0, fbLim_r};
						`SIA_OFF_DNUPER: prdata_nxt = {24'h0, dnuPer_r};
						`SIA_OFF_STNID: prdata_nxt = {22'h0, stnId_r};
						`SIA_OFF_HCMD: prdata_nxt = 32'h0;
						`SIA_OFF_ALARM: prdata_nxt = codesNow;
						`SIA_OFF_SATSEL: prdata_nxt = {27'h0, satSel_r};
						`SIA_OFF_SATSTAT: prdata_nxt = {28'h0, statusCode(mem.rdata, satTracked[satSel_r],
							bcastHealthy[satSel_r])};
						`SIA_OFF_FBSTAT: prdata_nxt = {16'h0, fbAge_r, 1'b0, wrongId_r, posFlag_r, stationHealth,
							unmonHeader};
						default: pslverr_nxt = 1'b1;
					endcase
				end
			end
			SIA_BUS_ACK: begin
				if (wrEn) begin
					unique case (paddr)
						`SIA_OFF_CTRL: begin
							onChg_nxt = pwdata[`SIA_CTRL_ONCHG_BIT];
							query_nxt = pwdata[`SIA_CTRL_QUERY_BIT];
							baseHlth_nxt = pwdata[`SIA_CTRL_HLTH_LSB +: 3];
						end
						`SIA_OFF_MINSAT: minSat_nxt = pwdata[5:0];
						`SIA_OFF_PRCLIM: pseudorangeLim_nxt = pwdata[15:0];
						`SIA_OFF_RRCLIM: rangeRateLim_nxt = pwdata[15:0];
						`SIA_OFF_FBLIM: fbLim_nxt = pwdata[7:0];
						`SIA_OFF_DNUPER: dnuPer_nxt = pwdata[7:0];
						`SIA_OFF_STNID: stnId_nxt = pwdata[9:0];
						`SIA_OFF_SATSEL: satSel_nxt = pwdata[4:0];
						`SIA_OFF_HCMD: begin
							if (hcmdSat == `SIA_ALL_SATS) begin
								sweepAct_nxt = 1'b1;
								sweepIdx_nxt = 5'h00;
								sweepCode_nxt = pwdata[`SIA_HCMD_CODE_LSB +: 2];
							end
						end
						default: ;
					endcase
				end
			end
		endcase
	end

	// reset wipes every override with a sweep of code 0
	always_ff @(posedge clk) begin
		if (!resetn) begin
			busSt_r <= SIA_BUS_IDLE;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			onChg_r <= 1'b1;
			query_r <= 1'b0;
			baseHlth_r <= 3'h0;
			minSat_r <= `SIA_RST_MINSAT;
			pseudorangeLim_r <= `SIA_RST_PRCLIM;
			rangeRateLim_r <= `SIA_RST_RRCLIM;
			fbLim_r <= `SIA_RST_FBLIM;
			dnuPer_r <= `SIA_RST_DNUPER;
			stnId_r <= `SIA_RST_STNID;
			satSel_r <= 5'h00;
			sweepAct_r <= 1'b1;
			sweepIdx_r <= 5'h00;
			sweepCode_r <= 2'h0;
		end else begin
			busSt_r <= busSt_nxt;
			prdata <= prdata_nxt;
			pready <= pready_nxt;
			pslverr <= pslverr_nxt;
			onChg_r <= onChg_nxt;
			query_r <= query_nxt;
			baseHlth_r <= baseHlth_nxt;
			minSat_r <= minSat_nxt;
			pseudorangeLim_r <= pseudorangeLim_nxt;
			rangeRateLim_r <= rangeRateLim_nxt;
			fbLim_r <= fbLim_nxt;
			dnuPer_r <= dnuPer_nxt;
			stnId_r <= stnId_nxt;
			satSel_r <= satSel_nxt;
			sweepAct_r <= sweepAct_nxt;
			sweepIdx_r <= sweepIdx_nxt;
			sweepCode_r <= sweepCode_nxt;
		end
	end

	logic [21:0] tickCnt_r, tickCnt_nxt;
	logic [3:0] secCnt_r, secCnt_nxt;
	logic tenthTick, secTick, fbMatch, fbTimeout;

	assign tenthTick = tickCnt_r == 22'(TICK_CYCLES - 1);
	assign secTick = tenthTick && secCnt_r == `SIA_TICKS_PER_SEC;
	assign fbMatch = fbValid && fbStationId == stnId_r;
	assign fbTimeout = fbAge_r >= fbLim_r;

	// time base and feedback tracking; every valid cycle is consumed
	always_comb begin
		tickCnt_nxt = tenthTick ? 22'h0 : tickCnt_r + 22'h1;
		secCnt_nxt = !tenthTick ? secCnt_r : (secTick ? 4'h0 : secCnt_r + 4'h1);
		fbAge_nxt = fbAge_r;
		posFlag_nxt = posFlag_r;
		wrongId_nxt = wrongId_r;
		if (fbMatch) begin
			fbAge_nxt = 8'h00;
			posFlag_nxt = fbPosFlag;
			wrongId_nxt = 1'b0;
		end else begin
			if (fbValid) begin
				wrongId_nxt = 1'b1;
			end
			if (tenthTick && fbAge_r != 8'hff) begin
				fbAge_nxt = fbAge_r + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tickCnt_r <= 22'h0;
			secCnt_r <= 4'h0;
			fbAge_r <= 8'h00;
			posFlag_r <= SIA_POS_INSIDE;
			wrongId_r <= 1'b0;
		end else begin
			tickCnt_r <= tickCnt_nxt;
			secCnt_r <= secCnt_nxt;
			fbAge_r <= fbAge_nxt;
			posFlag_r <= posFlag_nxt;
			wrongId_r <= wrongId_nxt;
		end
	end

	logic [31:0] alarmPrev_r, alarmPrev_nxt, reportCodes_nxt;
	logic reportValid_nxt, unmonHeader_nxt;
	logic [2:0] stationHealth_nxt;
	logic [7:0] unmonChar;

	// unmonitored cause, timeout first, then identifier, then monitor verdict
	always_comb begin
		unmonChar = `SIA_CH_M;
		if (fbTimeout) begin
			unmonChar = `SIA_CH_F;
		end else if (wrongId_r) begin
			unmonChar = `SIA_CH_W;
		end else if (posFlag_r != SIA_POS_INSIDE && posFlag_r != SIA_POS_OUTSIDE) begin
			unmonChar = `SIA_CH_U;
		end
	end

	assign codesNow = {almChar(satCount < minSat_r, `SIA_CH_I, `SIA_CH_S), unmonChar,
		almChar(pseudorangeMag > pseudorangeLim_r, `SIA_CH_H, `SIA_CH_N),
		almChar(rangeRateMag > rangeRateLim_r, `SIA_CH_H, `SIA_CH_N)};

	// one cycle from cause to report, far inside the half-second bound
	always_comb begin
		alarmPrev_nxt = codesNow;
		reportValid_nxt = (onChg_r && codesNow != alarmPrev_r) || query_r;
		reportCodes_nxt = reportValid_nxt ? codesNow : reportCodes;
		stationHealth_nxt = posFlag_r == SIA_POS_OUTSIDE ? `SIA_UNHEALTHY : baseHlth_r;
		unmonHeader_nxt = unmonChar != `SIA_CH_M;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			alarmPrev_r <= {`SIA_CH_S, `SIA_CH_M, `SIA_CH_N, `SIA_CH_N};
			reportValid <= 1'b0;
			reportCodes <= {`SIA_CH_S, `SIA_CH_M, `SIA_CH_N, `SIA_CH_N};
			stationHealth <= 3'h0;
			unmonHeader <= 1'b0;
		end else begin
			alarmPrev_r <= alarmPrev_nxt;
			reportValid <= reportValid_nxt;
			reportCodes <= reportCodes_nxt;
			stationHealth <= stationHealth_nxt;
			unmonHeader <= unmonHeader_nxt;
		end
	end

	logic [7:0] dnuTmr_r [NSAT];
	logic [7:0] dnuTmr_nxt [NSAT];
	logic [NSAT-1:0] dnuMask_nxt, smoothReset_nxt;

	// per-satellite do-not-use countdown in seconds; a new flag restarts it
	always_comb begin
		for (int i = 0; i < NSAT; i++) begin
			dnuTmr_nxt[i] = dnuTmr_r[i];
			smoothReset_nxt[i] = 1'b0;
			if (secTick && dnuTmr_r[i] != 8'h00) begin
				dnuTmr_nxt[i] = dnuTmr_r[i] - 8'h01;
				smoothReset_nxt[i] = dnuTmr_r[i] == 8'h01;
			end
			if (fbMatch && fbResidual == 6'(i + 1)) begin
				dnuTmr_nxt[i] = dnuPer_r == 8'h00 ? 8'h01 : dnuPer_r;
				smoothReset_nxt[i] = 1'b0;
			end
			dnuMask_nxt[i] = dnuTmr_nxt[i] != 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < NSAT; i++) begin
			dnuTmr_r[i] <= !resetn ? 8'h00 : dnuTmr_nxt[i];
		end
		dnuMask <= !resetn ? '0 : dnuMask_nxt;
		smoothReset <= !resetn ? '0 : smoothReset_nxt;
	end

	property p_allSats;
		@(posedge clk) disable iff (!resetn) (hcmdWr && hcmdSat == `SIA_ALL_SATS) |=>
			(sweepAct_r && sweepIdx_r == 5'h00) ##31 (sweepAct_r && sweepIdx_r == 5'h1f) ##1 !sweepAct_r;
	endproperty
	a_allSats: assert property (p_allSats) else $error("all-satellite sweep wrong");

	property p_noOvrCode;
		@(posedge clk) disable iff (!resetn) (busSt_r == SIA_BUS_IDLE && psel && penable && !pwrite &&
			!sweepAct_r && paddr == `SIA_OFF_SATSTAT && mem.rdata == SIA_OVR_NONE) |=> prdata <= 32'h2;
	endproperty
	a_noOvrCode: assert property (p_noOvrCode) else $error("status code above 2 without override");

	property p_forcedCode;
		@(posedge clk) disable iff (!resetn) (busSt_r == SIA_BUS_IDLE && psel && penable && !pwrite &&
			!sweepAct_r && paddr == `SIA_OFF_SATSTAT && mem.rdata == SIA_OVR_UNHEALTHY) |=> prdata >= 32'h6;
	endproperty
	a_forcedCode: assert property (p_forcedCode) else $error("forced unhealthy code wrong");

	property p_defaults;
		@(posedge clk) disable iff (!resetn) !$past(resetn) |-> (minSat_r == `SIA_RST_MINSAT &&
			fbLim_r == `SIA_RST_FBLIM && pseudorangeLim_r == `SIA_RST_PRCLIM && rangeRateLim_r == `SIA_RST_RRCLIM &&
			dnuPer_r == `SIA_RST_DNUPER);
	endproperty
	a_defaults: assert property (p_defaults) else $error("reset defaults wrong");

	property p_report;
		@(posedge clk) disable iff (!resetn) (onChg_r && codesNow != alarmPrev_r) |=>
			(reportValid && reportCodes == $past(codesNow));
	endproperty
	a_report: assert property (p_report) else $error("alarm change not reported");

	property p_fewSats;
		@(posedge clk) disable iff (!resetn) (onChg_r && satCount < minSat_r && alarmPrev_r[31:24] == `SIA_CH_S)
			|=> reportValid && reportCodes[31:24] == `SIA_CH_I;
	endproperty
	a_fewSats: assert property (p_fewSats) else $error("insufficient satellites not reported");

	property p_posOut;
		@(posedge clk) disable iff (!resetn) (fbMatch && fbPosFlag == SIA_POS_OUTSIDE) |=>
			##1 stationHealth == `SIA_UNHEALTHY;
	endproperty
	a_posOut: assert property (p_posOut) else $error("station health not unhealthy");

	property p_timeout;
		@(posedge clk) disable iff (!resetn) fbTimeout |=> unmonHeader && alarmPrev_r[23:16] == `SIA_CH_F;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout not unmonitored");

	property p_restart;
		@(posedge clk) disable iff (!resetn) (fbValid && !fbMatch && !tenthTick) |=> $stable(fbAge_r);
	endproperty
	a_restart: assert property (p_restart) else $error("foreign feedback touched timeout");

	property p_dnu;
		@(posedge clk) disable iff (!resetn) (fbMatch && fbResidual != 6'h00 && fbResidual <= 6'h20) |=>
			dnuMask[5'($past(fbResidual) - 6'h01)] && !smoothReset[5'($past(fbResidual) - 6'h01)];
	endproperty
	a_dnu: assert property (p_dnu) else $error("flagged satellite not do-not-use");
endmodule

// ---- sia_monitor_tb_top.sv ----
// Purpose: self-checking bench for the integrity alarm monitor
// Assumes: one second is ten ticks of ten cycles
// Notes: expected reads and reports are queued by the driver and matched by the watcher
`timescale 1ns/10ps
`include "sia_cfg.svh"
module sia_monitor_tb_top;
	logic clk;
	logic resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, fbValid, reportValid, unmonHeader;
	logic [5:0] satCount = 6'h08, fbResidual, fbRes = 6'h00;
	logic [15:0] pseudorangeMag = 16'h0064, rangeRateMag = 16'h000a;
	logic [31:0] satTracked = 32'h0, bcastHealthy = 32'h0, reportCodes, dnuMask, smoothReset;
	logic [9:0] fbStationId, fbId = 10'h000;
	logic [1:0] fbPosFlag, fbPos = 2'h0;
	logic dilutionHigh = 1'b0, fbOn = 1'b1;
	logic [2:0] stationHealth;
	logic [32:0] rdQ[$];
	logic [31:0] repQ[$];
	logic [31:0] codes[3] = '{"IMNN", "SMHN", "SMNH"};
	int failures = 0, checkCount = 0, cyc = 0, n, s;
	sia_monitor #(.TICK_CYCLES(10), .NSAT(32)) i_sia_monitor (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .satCount, .pseudorangeMag, .rangeRateMag, .satTracked, .bcastHealthy,
		.fbValid,
		.fbStationId, .fbPosFlag, .fbResidual, .reportValid, .reportCodes, .stationHealth, .unmonHeader,
		.dnuMask, .smoothReset);
	sia_fb_model i_sia_fb_model (.clk, .on(fbOn), .id(fbId), .pos(fbPos), .dilutionHigh, .res(fbRes), .fbValid,
		.fbStationId, .fbPosFlag, .fbResidual);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
		checkCount++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task conclude;
		if (failures == 0 && checkCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hang guard; the whole run needs well under 6000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end
	// the oldest note is matched against each read answer and each alarm report
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite)
			chk("read", {pslverr, prdata}, rdQ.pop_front());
		if (reportValid === 1'b1) begin
			if (repQ.size() == 0)
				chk("report", reportCodes, 36'hfffffffff);
			else
				chk("report", reportCodes, repQ.pop_front());
		end
	end
	// one apb transfer; the request stands until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		rdQ.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	// a report that misses its bound is counted once and dropped
	task automatic waitRep(input int lim);
		for (n = 0; n < lim && repQ.size() != 0; n++)
			@(posedge clk);
		if (repQ.size() != 0) begin
			chk("reportLate", 36'h0, 36'h1);
			repQ.delete();
		end
	endtask
	function automatic logic [3:0] stat(input logic [1:0] o, input logic t, input logic h);
		case (o)
			2'h1: stat = !t ? 4'h5 : (h ? 4'h4 : 4'h3);
			2'h2: stat = !t ? 4'h8 : (h ? 4'h6 : 4'h7);
			default: stat = !t ? 4'h0 : (h ? 4'h1 : 4'h2);
		endcase
	endfunction
	initial begin
		void'($urandom(32'h9df0c68a));
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		// reset values, then an unmapped place
		rd(`SIA_OFF_CTRL, 33'h1);
		rd(`SIA_OFF_MINSAT, 33'h3);
		rd(`SIA_OFF_FBLIM, 33'h1e);
		rd(`SIA_OFF_PRCLIM, 33'hfffe);
		rd(`SIA_OFF_RRCLIM, 33'h3e8);
		rd(`SIA_OFF_DNUPER, 33'h1e);
		rd(12'h0fc, 33'h100000000);
		// each threshold crossed, then brought back exactly to its limit, which is still normal
		for (int i = 0; i < 3; i++) begin
			repQ.push_back(codes[i]);
			if (i == 0)
				satCount <= 6'h02;
			else if (i == 1)
				pseudorangeMag <= 16'hffff;
			else
				rangeRateMag <= 16'h03e9;
			waitRep(52);
			repQ.push_back("SMNN");
			satCount <= 6'h03;
			pseudorangeMag <= 16'hfffe;
			rangeRateMag <= 16'h03e8;
			waitRep(52);
		end
		// foreign station id: wrong-id code, then timeout since own messages stopped
		repQ.push_back("SWNN");
		fbId <= 10'h005;
		waitRep(52);
		repQ.push_back("SFNN");
		waitRep(360);
		chk("unmonHeader", unmonHeader, 36'h1);
		repQ.push_back("SMNN");
		fbId <= 10'h000;
		waitRep(52);
		repQ.push_back("SUNN");
		dilutionHigh <= 1'b1;
		waitRep(52);
		repQ.push_back("SMNN");
		dilutionHigh <= 1'b0;
		waitRep(52);
		// position outside forces health 7, then the normal health field returns
		apb(1'b1, `SIA_OFF_CTRL, 32'h31);
		fbPos <= 2'h1;
		for (n = 0; n < 30 && stationHealth !== 3'h7; n++)
			@(posedge clk);
		chk("health", stationHealth, 36'h7);
		fbPos <= 2'h0;
		for (n = 0; n < 30 && stationHealth !== 3'h3; n++)
			@(posedge clk);
		chk("health", stationHealth, 36'h3);
		// residual at both ends of the satellite range, two-second do-not-use period
		apb(1'b1, `SIA_OFF_DNUPER, 32'h2);
		foreach (codes[i]) begin
			if (i == 2)
				break;
			s = (i == 0) ? 1 : 32;
			fbRes <= s[5:0];
			for (n = 0; n < 30 && dnuMask === 32'h0; n++)
				@(posedge clk);
			chk("dnuMask", dnuMask, 36'h1 << (s - 1));
			for (n = 0; n < 400 && smoothReset[s - 1] !== 1'b1; n++)
				@(posedge clk);
			chk("dnuTime", n >= 100 && n <= 300, 36'h1);
			@(posedge clk);
			chk("dnuMask", dnuMask, 36'h0);
			fbRes <= 6'h00;
			repeat (40) @(posedge clk);
		end
		// all-satellite overrides of codes 0, 1 and 2, then one satellite back to broadcast health
		satTracked <= $urandom();
		bcastHealthy <= $urandom();
		for (int c = 0; c < 3; c++) begin
			apb(1'b1, `SIA_OFF_HCMD, {22'h0, c[1:0], 1'b0, 7'h63});
			for (int j = 0; j < 4; j++) begin
				s = $urandom_range(0, 31);
				apb(1'b1, `SIA_OFF_SATSEL, {27'h0, s[4:0]});
				rd(`SIA_OFF_SATSTAT, {29'h0, stat(c[1:0], satTracked[s], bcastHealthy[s])});
			end
		end
		apb(1'b1, `SIA_OFF_HCMD, {22'h0, 2'h0, 1'b0, 7'h05});
		for (s = 4; s < 6; s++) begin
			apb(1'b1, `SIA_OFF_SATSEL, {27'h0, s[4:0]});
			rd(`SIA_OFF_SATSTAT, {29'h0, stat((s == 4) ? 2'h0 : 2'h2, satTracked[s], bcastHealthy[s])});
		end
		// query mode: silent on change, every query answered with cleared letters where normal
		repQ.push_back("SMNN");
		apb(1'b1, `SIA_OFF_CTRL, 32'h2);
		waitRep(10);
		satCount <= 6'h02;
		repeat (60) @(posedge clk);
		repQ.push_back("IMNN");
		apb(1'b1, `SIA_OFF_CTRL, 32'h2);
		waitRep(10);
		repeat (5) @(posedge clk);
		conclude();
	end
endmodule

// ---- sia_ovr_mem.sv ----
// Purpose: per-satellite health override store
// Assumes: synchronous write, registered read
// Notes: contents are cleared to no override at reset by the owner's sweep
`timescale 1ns/10ps
module sia_ovr_mem #(parameter int W = 2, parameter int D = 32, parameter int A = 5) (
	input wire logic clk,
	sia_mem_if.store mem
);
	logic [W-1:0] cells [D];
	// read before write, read data one cycle later from a register
	always_ff @(posedge clk) begin
		if (mem.we) begin
			cells[mem.waddr] <= mem.wdata;
		end
		mem.rdata <= cells[mem.raddr];
	end
endmodule

// ---- sia_pkg.sv ----
// Purpose: types of the integrity alarm monitor
// Assumes: nothing
// Notes: override code 3 is treated as no override
package sia_pkg;
	typedef enum logic [1:0] {SIA_OVR_NONE = 2'h0, SIA_OVR_HEALTHY = 2'h1, SIA_OVR_UNHEALTHY = 2'h2} sia_ovr_t;
	typedef enum logic [1:0] {SIA_POS_INSIDE = 2'h0, SIA_POS_OUTSIDE = 2'h1, SIA_POS_UNCHECKED = 2'h2} sia_pos_t;
	typedef enum logic [1:0] {SIA_BUS_IDLE = 2'b00, SIA_BUS_ACK = 2'b01} sia_bus_t;
endpackage
